// *** common/msc_consts.vh ***
// Constants for the motion sleep and output control block
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH
// Register addresses
`define MSC_ADDR_RATE     8'h2c
`define MSC_ADDR_CAUSE    8'h30
`define MSC_ADDR_FORMAT   8'h31
`define MSC_ADDR_AXIS0    8'h32
// Rate register fields
`define MSC_RATE_LSB      0
`define MSC_RATE_MSB      3
`define MSC_LOWPWR_BIT    4
`define MSC_RATE_RESET    8'h0a
// Format register fields
`define MSC_FORCE_BIT     7
`define MSC_JUSTIFY_BIT   2
`define MSC_FORMAT_RESET  8'h00
// Cause register fields
`define MSC_CAUSE_READY   7
`define MSC_CAUSE_ACT     4
`define MSC_CAUSE_INACT   3
// Rate codes
`define MSC_CODE_1600     4'he
`define MSC_CODE_3200     4'hf
`define MSC_CODE_SLEEP    4'h8
// Self-test settling in output sample periods
`define MSC_SETTLE_SAMPLES 3'h4
// Rate code of 3200 Hz; the decimation exponent is this minus the rate code
`define MSC_TOP_EXP       4'hf
`endif

// *** src/msc_decim.v ***
// Decimator that turns the base sample strobe into the output sample strobe
`timescale 1ns/1ps
module msc_decim (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Sample strobes
    input  wire        base_stb,
    input  wire [3:0]  rate_code,
    output reg         out_stb
);
    `include "msc_consts.vh"

    reg  [15:0] cnt_q;
    wire [15:0] limit;

    // Power of two ratio from the rate code
    assign limit = (rate_code >= `MSC_TOP_EXP) ? 16'h0000 :
                   (16'hffff >> (5'd16 - {1'b0, `MSC_TOP_EXP - rate_code}));

    always @(posedge sys_clk) begin
        if (rst) begin
            cnt_q   <= 16'h0000;
            out_stb <= 1'b0;
        end else begin
            out_stb <= 1'b0;
            if (base_stb) begin
                if (cnt_q >= limit) begin
                    cnt_q   <= 16'h0000;
                    out_stb <= 1'b1; // R1
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
        end
    end
endmodule // msc_decim

// *** src/msc_ctrl.v ***
// Sleep, wake, self-test and output formatting control of the motion sensor
`timescale 1ns/1ps
// What this block and its host do
// R1: Lower output rates are decimated from one base stream; activity uses base samples.
// R2: With link on, activity is searched for again only after inactivity.
// R3: Reading the cause register at 0x30 clears activity and inactivity flags.
// R4: An uncleared activity flag keeps the block out of automatic sleep.
// R5: With sleep, autosleep and link on, inactivity drops to a slow rate and arms activity.
// R6: Activity while asleep restores the rate, flags activity and rearms inactivity.
// R7: Reduced power keeps sample-ready and the sample path running.
// R8: The self-test force settles in the output within 4 output sample periods.
// R9: The rate register at 0x2c holds the rate code in bits 3 to 0.
// R10: Bit 4 of the rate register selects reduced power.
// R11: Bit 7 of the format register at 0x31 applies the self-test force.
// R12: Output codes scale at 48.83 mg per count.
// R13: At 3200 Hz and 1600 Hz the lowest data bit is always zero.
// R14: The lowest data bit sits at bit 0 right justified and bit 3 left justified.
// R15: The host reads samples in stream mode or right after sample-ready rises.
// R16: The host averages samples with and without force and takes the difference.
// R17: Each axis is twos complement over two bytes, low byte at the lower address.
module msc_ctrl (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // Mode controls
    input  wire        sleep_en,
    input  wire        autosleep_en,
    input  wire        link_en,
    // Sensor side
    input  wire        base_stb,
    input  wire [12:0] raw_x,
    input  wire [12:0] raw_y,
    input  wire [12:0] raw_z,
    input  wire        act_hit,
    input  wire        inact_hit,
    // Status outputs
    output reg         force_on,
    output reg         asleep,
    output reg         low_power,
    output reg         settled,
    output reg         act_armed,
    output reg         inact_armed
);
    `include "msc_consts.vh"

    // ******************************
    // Registers and state
    // ******************************
    reg  [7:0]  rate_q;
    reg  [7:0]  fmt_q;
    reg  [7:0]  cause_q;
    reg  [3:0]  saved_rate_q;
    reg  [2:0]  settle_q;
    reg  [15:0] ax_q [0:2];
    wire [3:0]  eff_rate;
    wire        out_stb;
    wire        act_ev;
    wire        inact_ev;
    wire        cause_rd;
    wire        rate_wr;
    wire        fmt_wr;
    wire        force_flip;

    localparam ST_AWAKE = 1'b0;
    localparam ST_SLEEP = 1'b1;

    // ******************************
    // Address decoding
    // ******************************
    function addr_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] want;
        begin
            addr_hit = strobe && (addr == want);
        end
    endfunction

    assign eff_rate = asleep ? `MSC_CODE_SLEEP : rate_q[`MSC_RATE_MSB:`MSC_RATE_LSB];
    assign cause_rd = addr_hit(reg_rd, reg_addr, `MSC_ADDR_CAUSE); // R3
    assign rate_wr  = addr_hit(reg_wr, reg_addr, `MSC_ADDR_RATE);
    assign fmt_wr   = addr_hit(reg_wr, reg_addr, `MSC_ADDR_FORMAT);
    // Write that toggles the self-test force
    assign force_flip = fmt_wr && (reg_wdata[`MSC_FORCE_BIT] != fmt_q[`MSC_FORCE_BIT]);
    // Activity judged on undecimated base samples
    assign act_ev   = base_stb && act_hit && act_armed;     // R1 R2
    assign inact_ev = base_stb && inact_hit && inact_armed;

    // ******************************
    // Output rate decimation
    // ******************************
    msc_decim u_decim (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .base_stb  (base_stb),
        .rate_code (eff_rate),
        .out_stb   (out_stb)
    );

    // ******************************
    // Formatting
    // ******************************
    function [15:0] fmt_word;
        input [12:0] raw;
        input        left;
        input [3:0]  code;
        reg   [12:0] v;
        begin
            v = raw; // R12
            if (code == `MSC_CODE_3200 || code == `MSC_CODE_1600)
                v[0] = 1'b0; // R13
            if (left)
                fmt_word = {v, 3'b000}; // R14
            else
                fmt_word = {{3{v[12]}}, v}; // R14 R17
        end
    endfunction

    // ******************************
    // Register writes and state
    // ******************************
    integer i;
    always @(posedge sys_clk) begin
        if (rst) begin
            rate_q       <= `MSC_RATE_RESET;
            fmt_q        <= `MSC_FORMAT_RESET;
            cause_q      <= 8'h00;
            saved_rate_q <= 4'h0;
            settle_q     <= 3'h0;
            asleep       <= ST_AWAKE;
            act_armed    <= 1'b1;
            inact_armed  <= 1'b1;
            for (i = 0; i < 3; i = i + 1)
                ax_q[i] <= 16'h0000;
        end else begin
            if (rate_wr)
                rate_q <= {3'b000, reg_wdata[4:0]}; // R9 R10
            if (fmt_wr)
                fmt_q <= reg_wdata; // R11
            if (force_flip) begin
                settle_q <= `MSC_SETTLE_SAMPLES; // R8
            end else if (out_stb && settle_q != 3'h0) begin
                settle_q <= settle_q - 3'h1; // R8
            end
            // Flags: set wins over read clear
            if (cause_rd) begin
                cause_q[`MSC_CAUSE_ACT]   <= 1'b0; // R3
                cause_q[`MSC_CAUSE_INACT] <= 1'b0; // R3
                cause_q[`MSC_CAUSE_READY] <= 1'b0;
            end
            if (out_stb) begin
                cause_q[`MSC_CAUSE_READY] <= 1'b1; // R7
                ax_q[0] <= fmt_word(raw_x, fmt_q[`MSC_JUSTIFY_BIT], eff_rate);
                ax_q[1] <= fmt_word(raw_y, fmt_q[`MSC_JUSTIFY_BIT], eff_rate);
                ax_q[2] <= fmt_word(raw_z, fmt_q[`MSC_JUSTIFY_BIT], eff_rate);
            end
            case (asleep)
                ST_AWAKE: begin
                    if (act_ev) begin
                        cause_q[`MSC_CAUSE_ACT] <= 1'b1;
                        if (link_en) begin
                            act_armed   <= 1'b0; // R2
                            inact_armed <= 1'b1;
                        end
                    end else if (inact_ev) begin
                        cause_q[`MSC_CAUSE_INACT] <= 1'b1;
                        if (link_en) begin
                            inact_armed <= 1'b0; // R5
                            act_armed   <= 1'b1; // R2
                        end
                        if (sleep_en && autosleep_en && link_en
                            && !cause_q[`MSC_CAUSE_ACT]) begin // R4
                            asleep       <= ST_SLEEP; // R5
                            saved_rate_q <= rate_q[3:0];
                        end
                    end
                end
                ST_SLEEP: begin
                    if (act_ev) begin
                        asleep                  <= ST_AWAKE; // R6
                        rate_q[3:0]             <= saved_rate_q; // R6
                        cause_q[`MSC_CAUSE_ACT] <= 1'b1; // R6
                        act_armed               <= 1'b0; // R6
                        inact_armed             <= 1'b1; // R6
                    end
                end
                default: asleep <= ST_AWAKE;
            endcase
        end
    end

    // ******************************
    // Read data and status
    // ******************************
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            force_on  <= 1'b0;
            low_power <= 1'b0;
            settled   <= 1'b1;
        end else begin
            force_on  <= fmt_q[`MSC_FORCE_BIT]; // R11
            low_power <= rate_q[`MSC_LOWPWR_BIT]; // R10 R7
            settled   <= (settle_q == 3'h0);
            case (reg_addr)
                `MSC_ADDR_RATE:   reg_rdata <= rate_q;
                `MSC_ADDR_CAUSE:  reg_rdata <= cause_q;
                `MSC_ADDR_FORMAT: reg_rdata <= fmt_q;
                8'h32:            reg_rdata <= ax_q[0][7:0]; // R17
                8'h33:            reg_rdata <= ax_q[0][15:8];
                8'h34:            reg_rdata <= ax_q[1][7:0];
                8'h35:            reg_rdata <= ax_q[1][15:8];
                8'h36:            reg_rdata <= ax_q[2][7:0];
                8'h37:            reg_rdata <= ax_q[2][15:8];
                default:          reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // msc_ctrl

// *** bench/msc_ctrl_sva.sv ***
// Assertion checker of the sleep and output control block
`timescale 1ns/1ps
module msc_sva (
    // Clock and reset
    input wire       sys_clk,
    input wire       rst,
    // Register port
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Mode and status
    input wire       link_en,
    input wire       base_stb,
    input wire       force_on,
    input wire       asleep,
    input wire       low_power,
    input wire       settled,
    input wire       act_armed,
    input wire       inact_armed
);
// ********************
// Properties
// ********************
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
property p_force;
    reg_wr && reg_addr == 8'h31 |-> ##2 force_on == $past(reg_wdata[7], 2);
endproperty
a_force: assert property (p_force) else $error("force level wrong");
property p_low;
    reg_wr && reg_addr == 8'h2c |-> ##2 low_power == $past(reg_wdata[4], 2);
endproperty
a_low: assert property (p_low) else $error("low power level wrong");
property p_settle;
    $changed(force_on) |-> ##[0:1] !settled;
endproperty
a_settle: assert property (p_settle) else $error("no settling after force change");
property p_clear;
    !$past(base_stb) && !base_stb && reg_rd && reg_addr == 8'h30 ##1
    !base_stb && reg_addr == 8'h30 |=> (reg_rdata & 8'h18) == 8'h00;
endproperty
a_clear: assert property (p_clear) else $error("cause flags not cleared");
property p_sleep;
    $rose(asleep) |-> link_en && $past(inact_armed);
endproperty
a_sleep: assert property (p_sleep) else $error("sleep without armed inactivity");
property p_arms;
    asleep && link_en |-> act_armed && !inact_armed;
endproperty
a_arms: assert property (p_arms) else $error("arming wrong while asleep");
property p_wake;
    $fell(asleep) |-> inact_armed && !act_armed;
endproperty
a_wake: assert property (p_wake) else $error("arming wrong after wake");
property p_link;
    link_en && $rose(act_armed) |-> !inact_armed;
endproperty
a_link: assert property (p_link) else $error("both detectors armed in link");
endmodule // msc_sva
bind msc_ctrl msc_sva u_msc_sva (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .link_en, .base_stb, .force_on, .asleep, .low_power, .settled, .act_armed,
    .inact_armed);

// *** bench/msc_host.sv ***
// Host model driving the register port
`timescale 1ns/1ps
module msc_host (
    // Clock
    input  wire       sys_clk,
    // Register port
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg        reg_rd,
    output reg  [7:0] reg_wdata,
    input  wire [7:0] reg_rdata
);
// ********************
// Bus cycles
// ********************
initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
end
task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~v;
    end
endtask
task rd(input [7:0] a, output [7:0] v);
    begin
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk) #1;
        reg_rd = 1'b0;
        v = reg_rdata;
    end
endtask
endmodule // msc_host

// *** bench/tb.sv ***
// Self-checking testbench of the sleep and output control block
`timescale 1ns/1ps
module tb;
// ********************
// Bench
// ********************
reg         sys_clk = 1'b0;
reg         rst = 1'b1;
reg         sleep_en = 1'b0;
reg         autosleep_en = 1'b0;
reg         link_en = 1'b0;
reg         base_stb = 1'b0;
reg         act_hit = 1'b0;
reg         inact_hit = 1'b0;
reg  [12:0] raw [0:2];
reg  [7:0]  d;
reg  [7:0]  h;
wire [7:0]  reg_addr, reg_rdata, reg_wdata;
wire        reg_wr, reg_rd, force_on, asleep, low_power, settled, act_armed, inact_armed;
integer     error_cnt = 0, n_tests = 0, tick = 0, i, k, n, seed;
integer     s_off, s_on, s_back;
wire [12:0] raw_z_in;
// Sensor shifts z while the self-test force is applied
assign raw_z_in = raw[2] + (force_on ? 13'h0040 : 13'h0000);
always #5 sys_clk = ~sys_clk;
always @(posedge sys_clk) begin
    #1;
    tick = tick + 1;
    base_stb = (tick % 4 == 0);
end
msc_host u_msc_host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
msc_ctrl u_msc_ctrl (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .sleep_en, .autosleep_en, .link_en, .base_stb, .raw_x(raw[0]), .raw_y(raw[1]),
    .raw_z(raw_z_in), .act_hit, .inact_hit, .force_on, .asleep, .low_power, .settled,
    .act_armed, .inact_armed);
function [15:0] word(input [12:0] r, input j, input [3:0] c);
    begin
        if (c >= 4'he) r[0] = 1'b0;
        word = j ? {r, 3'b000} : {{3{r[12]}}, r};
    end
endfunction
task chk(input [15:0] got, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task sync_ready;
    integer w;
    begin
        u_msc_host.rd(8'h30, d);
        d = 8'h00;
        w = 0;
        while (!d[7] && w < 100) begin
            u_msc_host.rd(8'h30, d);
            w = w + 1;
        end
        chk(d[7], 1'b1);
    end
endtask
task zavg(output integer s);
    integer m;
    begin
        s = 0;
        for (m = 0; m < 10; m = m + 1) begin
            sync_ready;
            u_msc_host.rd(8'h36, d);
            u_msc_host.rd(8'h37, h);
            s = s + $signed({h, d});
        end
    end
endtask
task hit(input a);
    begin
        act_hit = a;
        inact_hit = !a;
        repeat (6) @(posedge sys_clk) #1;
        act_hit = 1'b0;
        inact_hit = 1'b0;
        repeat (6) @(posedge sys_clk) #1;
    end
endtask
task end_sim;
    begin
        $display("checks=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    end
endtask
initial begin
    #1000000;
    error_cnt = error_cnt + 1;
    end_sim;
end
initial begin
    for (k = 0; k < 3; k = k + 1) raw[k] = 13'h0000;
    seed = $urandom(63);
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    u_msc_host.rd(8'h2c, d);
    chk(d, 8'h0a);
    u_msc_host.rd(8'h31, d);
    chk(d, 8'h00);
    u_msc_host.wr(8'h00, 8'h5a);
    u_msc_host.rd(8'h00, d);
    chk(d, 8'h00);
    u_msc_host.wr(8'h2c, 8'hff);
    u_msc_host.rd(8'h2c, d);
    chk(d, 8'h1f);
    for (i = 0; i < 6; i = i + 1) begin
        for (k = 0; k < 3; k = k + 1) raw[k] = 13'($urandom);
        u_msc_host.wr(8'h2c, {3'b000, i[0], 4'ha + i[3:0]});
        u_msc_host.wr(8'h31, {5'b00000, i[0], 2'b00});
        repeat (300) @(posedge sys_clk) #1;
        chk(low_power, i[0]);
        sync_ready;
        for (k = 0; k < 3; k = k + 1) begin
            u_msc_host.rd(8'(8'h32 + 2 * k), d);
            u_msc_host.rd(8'(8'h33 + 2 * k), h);
            chk({h, d}, word(raw[k], i[0], 4'ha + i[3:0]));
        end
    end
    raw[2] = {2'b00, 11'($urandom)};
    u_msc_host.wr(8'h31, 8'h00);
    zavg(s_off);
    for (i = 0; i < 2; i = i + 1) begin
        u_msc_host.wr(8'h31, {~i[0], 7'h00});
        @(posedge sys_clk) #1;
        n = 0;
        while (!settled && n < 40) begin
            @(posedge sys_clk) #1;
            n = n + 1;
        end
        chk(n > 7 && n < 19, 1'b1);
        chk(force_on, !i[0]);
        if (i == 0) zavg(s_on);
        else zavg(s_back);
    end
    chk(16'(s_on - s_off), 16'h0280);
    chk(16'(s_back - s_off), 16'h0000);
    u_msc_host.wr(8'h2c, 8'h0d);
    u_msc_host.rd(8'h30, d);
    sleep_en = 1'b1;
    autosleep_en = 1'b1;
    link_en = 1'b1;
    hit(1'b1);
    hit(1'b0);
    chk(asleep, 1'b0);
    u_msc_host.rd(8'h30, d);
    chk(d[4], 1'b1);
    u_msc_host.rd(8'h30, d);
    chk(d & 8'h18, 8'h00);
    hit(1'b1);
    u_msc_host.rd(8'h30, d);
    hit(1'b0);
    chk({asleep, act_armed, inact_armed}, 3'b110);
    hit(1'b1);
    chk({asleep, act_armed, inact_armed}, 3'b001);
    u_msc_host.rd(8'h30, d);
    chk(d[4], 1'b1);
    u_msc_host.rd(8'h2c, d);
    chk(d, 8'h0d);
    end_sim;
end
endmodule // tb
